// ===== core/addr_table_class.sv
// Decided for this implementation: strobed register access and the address map.
`timescale 1ns/1ps
module addr_table_class #(
    parameter int ENTRIES     = 32,
    parameter int TICK_CYCLES = atab_pkg::TICK_CYCLES
) (
    // clock and reset
    input  wire logic        i_clock,
    input  wire logic        i_rst,
    // register port
    input  wire logic [7:0]  i_addr,
    input  wire logic [31:0] i_wr_data,
    input  wire logic        i_wr_strobe,
    input  wire logic        i_rd_strobe,
    output logic      [31:0] o_rd_data,
    // lookup request
    input  wire logic        i_lk_valid,
    input  wire logic [47:0] i_lk_src,
    input  wire logic [47:0] i_lk_dst,
    input  wire logic [4:0]  i_lk_port,
    input  wire logic        i_lk_tagged,
    input  wire logic [2:0]  i_lk_prio,
    input  wire logic [11:0] i_lk_vid,
    // lookup result
    output logic             o_res_valid,
    output logic             o_res_drop,
    output logic             o_res_flood,
    output logic      [4:0]  o_res_port,
    output logic      [2:0]  o_res_class,
    output logic      [1:0]  o_res_queue,
    output logic             o_res_mgmt_ok,
    // output queue service
    input  wire logic [3:0]  i_q_nonempty,
    input  wire logic        i_q_take,
    output logic             o_q_grant_valid,
    output logic      [1:0]  o_q_grant
);

localparam int IW = $clog2(ENTRIES);
localparam int TW = $clog2(TICK_CYCLES);

typedef struct packed {
    logic          hit;
    logic [IW-1:0] idx;
} found_t;

// table storage
logic                vld_q  [ENTRIES];
logic                hit_q  [ENTRIES];
atab_pkg::kind_t     kind_q [ENTRIES];
logic [47:0]         mac_q  [ENTRIES];
logic [4:0]          port_q [ENTRIES];
logic [2:0]          cls_q  [ENTRIES];

// configuration
logic                strict_q;
logic [31:0]         learn_en_q;
logic [19:0]         age_q;
logic [31:0]         mac_lo_q;
logic [15:0]         mac_hi_q;
logic [23:0]         prio_map_q;
logic [15:0]         qmap_q;
logic [15:0]         weights_q;
logic [2:0]          port_cls_q [32];
logic                fail_q;

// aging
logic [TW-1:0]       tick_q;
logic [19:0]         sec_q;
logic                sec_tick;
logic                scan_go;

// lookup and command decode
found_t              src_f;
found_t              dst_f;
found_t              flt_f;
found_t              cls_f;
found_t              vlan_f;
found_t              bnd_f;
found_t              free_f;
found_t              cmd_f;
logic [2:0]          mac_cls;
logic [2:0]          vlan_cls;
logic [2:0]          prio_cls;
logic [2:0]          cls_d;
logic                mgmt_d;
logic                learn_new;
logic                learn_move;
logic                cmd_go;
atab_pkg::op_t       cmd_op;
atab_pkg::kind_t     cmd_kind;
logic [5:0]          cmd_mask;
logic [47:0]         cmd_mac;
logic                add_ok;
logic [IW-1:0]       add_idx;
logic [IW:0]         count_d;
logic [31:0]         status_w;

sched_if sif ();

// lowest valid entry of the given kinds holding this address
function automatic found_t find(input logic [47:0] m, input logic [5:0] kinds);
    found_t f;
    f = '0;
    for (int i = ENTRIES - 1; i >= 0; i--) begin
        if (vld_q[i] && kinds[kind_q[i]] && mac_q[i] == m) begin
            f.hit = 1'h1;
            f.idx = IW'(i);
        end
    end
    return f;
endfunction

function automatic found_t free_slot();
    found_t f;
    f = '0;
    for (int i = ENTRIES - 1; i >= 0; i--) begin
        if (!vld_q[i]) begin
            f.hit = 1'h1;
            f.idx = IW'(i);
        end
    end
    return f;
endfunction

assign cmd_go   = i_wr_strobe && i_addr == atab_pkg::REG_CMD;
assign cmd_op   = atab_pkg::op_t'(i_wr_data[atab_pkg::CMD_OP_LSB +: 2]);
assign cmd_kind = atab_pkg::kind_t'(i_wr_data[atab_pkg::CMD_KIND_LSB +: 3]);
assign cmd_mac  = {mac_hi_q, mac_lo_q};
// any address kind replaces another, so a static add converts a learned one
assign cmd_mask = atab_pkg::M_ADDR[cmd_kind] ? atab_pkg::M_ADDR : (6'h01 << cmd_kind);

assign src_f  = find(i_lk_src, atab_pkg::M_ADDR);
assign dst_f  = find(i_lk_dst, atab_pkg::M_ADDR);
assign flt_f  = find(i_lk_dst, atab_pkg::M_FILTER);
assign cls_f  = find(i_lk_src, atab_pkg::M_CLASS);
assign vlan_f = find({36'h0, i_lk_vid}, atab_pkg::M_VLAN);
assign bnd_f  = find(i_lk_src, atab_pkg::M_BOUND);
assign free_f = free_slot();
assign cmd_f  = find(cmd_mac, cmd_mask);

assign add_ok  = cmd_f.hit || free_f.hit;
assign add_idx = cmd_f.hit ? cmd_f.idx : free_f.idx;

assign mac_cls  = cls_q[cls_f.idx];
assign vlan_cls = cls_q[vlan_f.idx];
assign prio_cls = prio_map_q[3*i_lk_prio +: 3];

// precedence: station address, then VLAN, then tag, then ingress port
always_comb begin
    if (cls_f.hit) begin
        cls_d = mac_cls;
    end else if (vlan_f.hit) begin
        cls_d = vlan_cls;
    end else if (i_lk_tagged) begin
        cls_d = prio_cls;
    end else begin
        cls_d = port_cls_q[i_lk_port];
    end
end

assign mgmt_d = bnd_f.hit && port_q[bnd_f.idx] == i_lk_port;

// management writes win the table this cycle; the frame relearns later
assign learn_new = i_lk_valid && !cmd_go && learn_en_q[i_lk_port]
                   && !src_f.hit && free_f.hit;
assign learn_move = i_lk_valid && !cmd_go && learn_en_q[i_lk_port] && src_f.hit
                    && kind_q[src_f.idx] == atab_pkg::K_DYN
                    && port_q[src_f.idx] != i_lk_port;

always_ff @(posedge i_clock or posedge i_rst) begin
    if (i_rst) begin
        for (int i = 0; i < ENTRIES; i++) begin
            vld_q[i] <= 1'h0;
            hit_q[i] <= 1'h0;
            kind_q[i] <= atab_pkg::K_DYN;
            mac_q[i] <= 48'h0;
            port_q[i] <= 5'h0;
            cls_q[i] <= 3'h0;
        end
    end else begin
        if (scan_go) begin
            for (int i = 0; i < ENTRIES; i++) begin
                if (vld_q[i] && kind_q[i] == atab_pkg::K_DYN && !hit_q[i]) begin
                    vld_q[i] <= 1'h0;
                end
                hit_q[i] <= 1'h0;
            end
        end
        // a hit in the scan cycle survives the clear
        if (i_lk_valid && src_f.hit) begin
            hit_q[src_f.idx] <= 1'h1;
        end
        if (i_lk_valid && dst_f.hit) begin
            hit_q[dst_f.idx] <= 1'h1;
        end
        if (learn_new) begin
            vld_q[free_f.idx] <= 1'h1;
            hit_q[free_f.idx] <= 1'h1;
            kind_q[free_f.idx] <= atab_pkg::K_DYN;
            mac_q[free_f.idx] <= i_lk_src;
            port_q[free_f.idx] <= i_lk_port;
            cls_q[free_f.idx] <= 3'h0;
        end
        if (learn_move) begin
            port_q[src_f.idx] <= i_lk_port;
        end
        if (cmd_go && cmd_op == atab_pkg::OP_ADD && add_ok) begin
            vld_q[add_idx] <= 1'h1;
            hit_q[add_idx] <= 1'h1;
            kind_q[add_idx] <= cmd_kind;
            mac_q[add_idx] <= cmd_mac;
            port_q[add_idx] <= i_wr_data[atab_pkg::CMD_PORT_LSB +: atab_pkg::PORT_W];
            cls_q[add_idx] <= i_wr_data[atab_pkg::CMD_CLASS_LSB +: 3];
        end
        if (cmd_go && cmd_op == atab_pkg::OP_DEL && cmd_f.hit) begin
            vld_q[cmd_f.idx] <= 1'h0;
        end
    end
end

// one-second enable, then a scan every aging period
assign sec_tick = tick_q == TW'(TICK_CYCLES - 1);
assign scan_go  = sec_tick && (sec_q + 20'h1 >= age_q);

always_ff @(posedge i_clock or posedge i_rst) begin
    if (i_rst) begin
        tick_q <= '0;
        sec_q <= 20'h0;
    end else begin
        tick_q <= sec_tick ? '0 : tick_q + 1'h1;
        if (scan_go) begin
            sec_q <= 20'h0;
        end else if (sec_tick) begin
            sec_q <= sec_q + 20'h1;
        end
    end
end

always_ff @(posedge i_clock or posedge i_rst) begin
    if (i_rst) begin
        strict_q <= 1'h0;
        learn_en_q <= atab_pkg::LEARN_RESET;
        age_q <= atab_pkg::AGE_DEFAULT_S;
        mac_lo_q <= 32'h0;
        mac_hi_q <= 16'h0;
        prio_map_q <= atab_pkg::PRIO_MAP_RESET;
        qmap_q <= atab_pkg::QUEUE_MAP_RESET;
        weights_q <= atab_pkg::WEIGHTS_RESET;
        for (int p = 0; p < 32; p++) begin
            port_cls_q[p] <= 3'h0;
        end
    end else if (i_wr_strobe) begin
        case (i_addr)
            atab_pkg::REG_CTRL: strict_q <= i_wr_data[atab_pkg::CTRL_STRICT_BIT];
            atab_pkg::REG_LEARN: learn_en_q <= i_wr_data;
            atab_pkg::REG_AGE: begin
                if (i_wr_data < 32'(atab_pkg::AGE_MIN_S)) begin
                    age_q <= atab_pkg::AGE_MIN_S;
                end else if (i_wr_data > 32'(atab_pkg::AGE_MAX_S)) begin
                    age_q <= atab_pkg::AGE_MAX_S;
                end else begin
                    age_q <= i_wr_data[atab_pkg::AGE_W-1:0];
                end
            end
            atab_pkg::REG_MAC_LO: mac_lo_q <= i_wr_data;
            atab_pkg::REG_MAC_HI: mac_hi_q <= i_wr_data[15:0];
            atab_pkg::REG_PRIO_MAP: prio_map_q <= i_wr_data[23:0];
            atab_pkg::REG_QUEUE_MAP: qmap_q <= i_wr_data[15:0];
            atab_pkg::REG_WEIGHTS: weights_q <= i_wr_data[15:0];
            atab_pkg::REG_PORT_CLASS: begin
                port_cls_q[i_wr_data[atab_pkg::CMD_PORT_LSB +: atab_pkg::PORT_W]]
                    <= i_wr_data[atab_pkg::CMD_CLASS_LSB +: 3];
            end
            default: ;
        endcase
    end
end

// failed add is sticky; a new failure wins over a clear
always_ff @(posedge i_clock or posedge i_rst) begin
    if (i_rst) begin
        fail_q <= 1'h0;
    end else if (cmd_go && cmd_op == atab_pkg::OP_ADD && !add_ok) begin
        fail_q <= 1'h1;
    end else if (i_wr_strobe && i_addr == atab_pkg::REG_STATUS
                 && i_wr_data[atab_pkg::STATUS_FAIL_BIT]) begin
        fail_q <= 1'h0;
    end
end

always_comb begin
    count_d = '0;
    for (int i = 0; i < ENTRIES; i++) begin
        if (vld_q[i]) count_d = count_d + 1'h1;
    end
    status_w = 32'h0;
    status_w[atab_pkg::STATUS_COUNT_LSB +: IW + 1] = count_d;
    status_w[atab_pkg::STATUS_FAIL_BIT] = fail_q;
end

always_ff @(posedge i_clock or posedge i_rst) begin
    if (i_rst) begin
        o_rd_data <= 32'h0;
    end else if (i_rd_strobe) begin
        case (i_addr)
            atab_pkg::REG_CTRL: o_rd_data <= 32'(strict_q);
            atab_pkg::REG_LEARN: o_rd_data <= learn_en_q;
            atab_pkg::REG_AGE: o_rd_data <= 32'(age_q);
            atab_pkg::REG_MAC_LO: o_rd_data <= mac_lo_q;
            atab_pkg::REG_MAC_HI: o_rd_data <= 32'(mac_hi_q);
            atab_pkg::REG_STATUS: o_rd_data <= status_w;
            atab_pkg::REG_PRIO_MAP: o_rd_data <= 32'(prio_map_q);
            atab_pkg::REG_QUEUE_MAP: o_rd_data <= 32'(qmap_q);
            atab_pkg::REG_WEIGHTS: o_rd_data <= 32'(weights_q);
            default: o_rd_data <= 32'h0;
        endcase
    end else begin
        o_rd_data <= 32'h0;
    end
end

always_ff @(posedge i_clock or posedge i_rst) begin
    if (i_rst) begin
        o_res_valid <= 1'h0;
        o_res_drop <= 1'h0;
        o_res_flood <= 1'h0;
        o_res_port <= 5'h0;
        o_res_class <= 3'h0;
        o_res_queue <= 2'h0;
        o_res_mgmt_ok <= 1'h0;
    end else begin
        o_res_valid <= i_lk_valid;
        if (i_lk_valid) begin
            o_res_drop <= flt_f.hit;
            o_res_flood <= !flt_f.hit && !dst_f.hit;
            o_res_port <= dst_f.hit ? port_q[dst_f.idx] : 5'h0;
            o_res_class <= cls_d;
            o_res_queue <= qmap_q[2*cls_d +: 2];
            o_res_mgmt_ok <= mgmt_d;
        end
    end
end

assign sif.nonempty  = i_q_nonempty;
assign sif.take      = i_q_take;
assign sif.strict    = strict_q;
assign sif.weights   = weights_q;
assign o_q_grant_valid = sif.gvalid;
assign o_q_grant       = sif.grant;

queue_sched u_sched (
    .i_clock (i_clock),
    .i_rst   (i_rst),
    .bus     (sif.sched)
);

default clocking cb @(posedge i_clock);
endclocking
default disable iff (i_rst);

a_filter_drop: assert property (
    i_lk_valid && flt_f.hit |=> o_res_valid && o_res_drop && !o_res_flood)
    else $error("filtered destination was not dropped");

a_miss_flood: assert property (
    i_lk_valid && !dst_f.hit && !flt_f.hit |=> o_res_flood && o_res_port == 5'h0)
    else $error("destination miss was not flooded");

a_age_bounds: assert property (
    age_q >= atab_pkg::AGE_MIN_S && age_q <= atab_pkg::AGE_MAX_S)
    else $error("aging time outside allowed range");

a_mgmt_bound: assert property (
    o_res_valid && o_res_mgmt_ok |-> $past(bnd_f.hit))
    else $error("management granted to unbound source");

a_class_entry: assert property (
    i_lk_valid && cls_f.hit |=> o_res_class == $past(mac_cls))
    else $error("address class entry not applied");

a_prio_decode: assert property (
    i_lk_valid && i_lk_tagged && !cls_f.hit && !vlan_f.hit
    |=> o_res_class == $past(prio_cls))
    else $error("tag priority not decoded to class");

a_queue_map: assert property (
    o_res_valid && $stable(qmap_q) |-> o_res_queue == qmap_q[2*o_res_class +: 2])
    else $error("class to queue mapping wrong");

a_learn_gate: assert property (
    i_lk_valid && !learn_en_q[i_lk_port] && !cmd_go && !scan_go
    |=> count_d == $past(count_d))
    else $error("entry learned on a disabled port");

for (genvar g = 0; g < ENTRIES; g++) begin : g_entry
    sequence s_stale;
        scan_go && vld_q[g] && kind_q[g] == atab_pkg::K_DYN && !hit_q[g] && !cmd_go;
    endsequence
    a_age_remove: assert property (s_stale |=> !vld_q[g])
        else $error("stale dynamic entry survived a scan");
    a_static_kept: assert property (
        vld_q[g] && kind_q[g] != atab_pkg::K_DYN && !cmd_go |=> vld_q[g])
        else $error("configured entry removed without command");
end

endmodule

// ===== core/queue_sched.sv
`timescale 1ns/1ps
module queue_sched (
    // clock and reset
    input  wire logic i_clock,
    input  wire logic i_rst,
    // scheduler link
    sched_if.sched    bus
);

logic [1:0] ptr_q;
logic [1:0] ptr_d;
logic [3:0] cred_q;
logic [3:0] cred_d;
logic [3:0] cnt;

// zero weight would starve a queue forever, so it counts as one
function automatic logic [3:0] weight(input logic [15:0] w, input logic [1:0] q);
    return (w[4*q +: 4] == 4'h0) ? 4'h1 : w[4*q +: 4];
endfunction

function automatic logic [1:0] pick(input logic [3:0] ne, input logic strict,
                                    input logic [1:0] ptr);
    logic [1:0] g;
    logic [1:0] q;
    g = ptr;
    q = ptr;
    if (strict) begin
        for (int k = 0; k < 4; k++) begin
            if (ne[k]) g = 2'(k);
        end
    end else begin
        for (int k = 3; k >= 0; k--) begin
            q = ptr + 2'(k);
            if (ne[q]) g = q;
        end
    end
    return g;
endfunction

always_comb begin
    cnt = (bus.grant == ptr_q) ? cred_q + 4'h1 : 4'h1;
    ptr_d = ptr_q;
    cred_d = cred_q;
    if (bus.take && bus.gvalid) begin
        if (cnt >= weight(bus.weights, bus.grant)) begin
            ptr_d = bus.grant + 2'h1;
            cred_d = 4'h0;
        end else begin
            ptr_d = bus.grant;
            cred_d = cnt;
        end
    end
end

always_ff @(posedge i_clock or posedge i_rst) begin
    if (i_rst) begin
        ptr_q <= 2'h0;
        cred_q <= 4'h0;
        bus.grant <= 2'h0;
        bus.gvalid <= 1'h0;
    end else begin
        ptr_q <= ptr_d;
        cred_q <= cred_d;
        bus.grant <= pick(bus.nonempty, bus.strict, ptr_d);
        bus.gvalid <= |bus.nonempty;
    end
end

a_strict_first: assert property (@(posedge i_clock) disable iff (i_rst)
    bus.gvalid && $past(bus.strict) |-> ($past(bus.nonempty) >> bus.grant) == 4'h1)
    else $error("strict grant is not the highest waiting queue");

endmodule

// ===== pkg/atab_pkg.sv
package atab_pkg;
    // register byte offsets
    localparam logic [7:0] REG_CTRL       = 8'h00;
    localparam logic [7:0] REG_LEARN      = 8'h04;
    localparam logic [7:0] REG_AGE        = 8'h08;
    localparam logic [7:0] REG_MAC_LO     = 8'h0c;
    localparam logic [7:0] REG_MAC_HI     = 8'h10;
    localparam logic [7:0] REG_CMD        = 8'h14;
    localparam logic [7:0] REG_STATUS     = 8'h18;
    localparam logic [7:0] REG_PRIO_MAP   = 8'h1c;
    localparam logic [7:0] REG_QUEUE_MAP  = 8'h20;
    localparam logic [7:0] REG_WEIGHTS    = 8'h24;
    localparam logic [7:0] REG_PORT_CLASS = 8'h28;

    // field positions
    localparam int CTRL_STRICT_BIT  = 0;
    localparam int CMD_OP_LSB       = 0;
    localparam int CMD_KIND_LSB     = 4;
    localparam int CMD_PORT_LSB     = 8;
    localparam int CMD_CLASS_LSB    = 16;
    localparam int STATUS_FAIL_BIT  = 0;
    localparam int STATUS_COUNT_LSB = 8;
    localparam int PORT_W           = 5;
    localparam int AGE_W            = 20;

    // reset values and aging limits
    localparam logic [19:0] AGE_DEFAULT_S   = 20'h0012c;
    localparam logic [19:0] AGE_MIN_S       = 20'h0001e;
    localparam logic [19:0] AGE_MAX_S       = 20'hf4240;
    localparam logic [31:0] LEARN_RESET     = 32'hffffffff;
    localparam logic [23:0] PRIO_MAP_RESET  = 24'hfac688;
    localparam logic [15:0] QUEUE_MAP_RESET = 16'hfa50;
    localparam logic [15:0] WEIGHTS_RESET   = 16'h8421;

    // timing: one aging step is one second
    localparam int CLK_PERIOD_NS = 20;
    localparam int AGE_STEP_S    = 1;
    localparam int NS_PER_S      = 32'h3b9aca00;
    localparam int TICK_CYCLES   = AGE_STEP_S * NS_PER_S / CLK_PERIOD_NS;

    typedef enum logic [2:0] {K_DYN, K_STATIC, K_BOUND, K_FILTER, K_CLASS, K_VLAN} kind_t;
    typedef enum logic [1:0] {OP_NONE, OP_ADD, OP_DEL} op_t;

    // kind masks, one bit per kind_t value
    localparam logic [5:0] M_ADDR   = 6'h07;
    localparam logic [5:0] M_BOUND  = 6'h04;
    localparam logic [5:0] M_FILTER = 6'h08;
    localparam logic [5:0] M_CLASS  = 6'h10;
    localparam logic [5:0] M_VLAN   = 6'h20;
endpackage

// ===== pkg/sched_if.sv
`timescale 1ns/1ps
interface sched_if;
    logic [3:0]  nonempty;
    logic        take;
    logic        strict;
    logic [15:0] weights;
    logic        gvalid;
    logic [1:0]  grant;
    modport ctrl  (output nonempty, take, strict, weights, input gvalid, grant);
    modport sched (input nonempty, take, strict, weights, output gvalid, grant);
endinterface

// ===== test/queue_sink.sv
`timescale 1ns/1ps
module queue_sink (
    // clock and reset
    input  wire logic            i_clock,
    input  wire logic            i_rst,
    // bench control
    input  wire logic [3:0]      i_mask,
    input  wire logic            i_run,
    input  wire logic            i_slow,
    input  wire logic [4:0]      i_limit,
    // scheduler side
    input  wire logic            i_grant_valid,
    input  wire logic [1:0]      i_grant,
    output logic      [3:0]      o_nonempty,
    output logic                 o_take,
    output logic      [3:0][4:0] o_served,
    output logic      [4:0]      o_total
);
    assign o_nonempty = i_mask;
    // a take only counts at an edge where the grant is valid
    always_ff @(posedge i_clock or posedge i_rst) begin
        if (i_rst) begin
            o_take   <= 1'b0;
            o_served <= '0;
            o_total  <= 5'h00;
        end else begin
            if (o_take && i_grant_valid) begin
                o_served[i_grant] <= o_served[i_grant] + 5'h01;
                o_total           <= o_total + 5'h01;
            end
            // slow mode stalls one cycle after every take
            o_take <= i_run && i_grant_valid && !(i_slow && o_take)
                && (o_total + 5'(o_take && i_grant_valid) + 5'h01 <= i_limit);
        end
    end
endmodule

// ===== test/tb_addr_table_class.sv
`timescale 1ns/1ps
`define chk(w, e, g) begin checks++; if ((g) !== (e)) begin failures++; \
    $display("unexpected %s expected %0h seen %0h", w, e, g); end end

module tb_addr_table_class;
    typedef struct {
        logic [47:0] src;
        logic [47:0] dst;
        logic [4:0]  port;
        logic        tg;
        logic [2:0]  prio;
        logic [11:0] vid;
        logic        drop;
        logic        flood;
        logic [4:0]  oport;
        logic [2:0]  cls;
        logic        mok;
    } row_t;
    localparam logic [47:0] mac_a = 48'h0a0000000001;
    localparam logic [47:0] mac_b = 48'h0a0000000002;
    localparam logic [47:0] mac_c = 48'h0a0000000003;
    localparam logic [47:0] mac_d = 48'h0a0000000004;
    localparam logic [47:0] mac_l = 48'h020000000021;
    logic            i_clock  = 1'b0;
    logic            i_rst    = 1'b1;
    logic [7:0]      addr     = 8'h00;
    logic [31:0]     wdata    = 32'h0;
    logic            wr       = 1'b0;
    logic            rd       = 1'b0;
    logic            lv       = 1'b0;
    row_t            req      = '{default: '0};
    logic [3:0]      mask     = 4'h0;
    logic            run      = 1'b0;
    logic            slow     = 1'b0;
    logic [31:0]     rdata;
    logic            rv;
    logic            drop;
    logic            flood;
    logic            mok;
    logic            gv;
    logic            take;
    logic [4:0]      oport;
    logic [4:0]      total;
    logic [2:0]      cls;
    logic [1:0]      que;
    logic [1:0]      grant;
    logic [3:0]      nonempty;
    logic [3:0][4:0] served;
    int              failures = 0;
    int              checks   = 0;
    int              cyc      = 0;
    row_t            rows [10];

    addr_table_class #(.ENTRIES(32), .TICK_CYCLES(8)) DUT (
        .i_clock(i_clock), .i_rst(i_rst), .i_addr(addr), .i_wr_data(wdata),
        .i_wr_strobe(wr), .i_rd_strobe(rd), .o_rd_data(rdata), .i_lk_valid(lv),
        .i_lk_src(req.src), .i_lk_dst(req.dst), .i_lk_port(req.port),
        .i_lk_tagged(req.tg), .i_lk_prio(req.prio), .i_lk_vid(req.vid),
        .o_res_valid(rv), .o_res_drop(drop), .o_res_flood(flood), .o_res_port(oport),
        .o_res_class(cls), .o_res_queue(que), .o_res_mgmt_ok(mok),
        .i_q_nonempty(nonempty), .i_q_take(take), .o_q_grant_valid(gv), .o_q_grant(grant));
    queue_sink sink (
        .i_clock(i_clock), .i_rst(i_rst), .i_mask(mask), .i_run(run), .i_slow(slow),
        .i_limit(5'h0f), .i_grant_valid(gv), .i_grant(grant), .o_nonempty(nonempty),
        .o_take(take), .o_served(served), .o_total(total));

    initial begin
        forever #10 i_clock = ~i_clock;
    end

    task automatic conclude();
        $display("checks %0d failures %0d", checks, failures);
        if (failures == 0 && checks > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask

    // generous ceiling; the whole sequence needs under 2000 cycles
    always @(posedge i_clock) begin
        cyc++;
        if (cyc == 20000) begin
            failures++;
            conclude();
        end
    end

    task automatic wreg(input logic [7:0] a, input logic [31:0] d);
        @(posedge i_clock);
        addr  <= a;
        wdata <= d;
        wr    <= 1'b1;
        @(posedge i_clock);
        wr <= 1'b0;
    endtask

    task automatic creg(input logic [7:0] a, input logic [31:0] e);
        @(posedge i_clock);
        addr <= a;
        rd   <= 1'b1;
        @(posedge i_clock);
        rd <= 1'b0;
        #1;
        `chk("register", e, rdata)
    endtask

    task automatic ent(input logic [1:0] op, input logic [2:0] k, input logic [47:0] m,
                       input logic [4:0] p, input logic [2:0] c);
        wreg(atab_pkg::REG_MAC_LO, m[31:0]);
        wreg(atab_pkg::REG_MAC_HI, {16'h0000, m[47:32]});
        wreg(atab_pkg::REG_CMD, {13'h0000, c, 3'h0, p, 1'b0, k, 2'h0, op});
    endtask

    task automatic look(input row_t r);
        @(posedge i_clock);
        req <= r;
        lv  <= 1'b1;
        @(posedge i_clock);
        lv <= 1'b0;
        #1;
        `chk("valid", 1'b1, rv)
    endtask

    task automatic probe(input logic [47:0] d, input logic f, input logic [4:0] p);
        look('{48'h0e0000000000, d, 5'h03, 1'b0, 3'h0, 12'h001, 1'b0, f, p, 3'h0, 1'b0});
        `chk("flood", f, flood)
        `chk("port", p, oport)
    endtask

    initial begin
        rows[0] = '{48'h020000000010, mac_a, 5'h01, 1'b0, 3'h0, 12'h001, 0, 0, 5'h03, 3'h0, 0};
        rows[1] = '{48'h020000000011, mac_c, 5'h01, 1'b0, 3'h0, 12'h001, 1, 0, 5'h00, 3'h0, 0};
        rows[2] = '{48'h020000000012, 48'h0f, 5'h01, 1'b0, 3'h0, 12'h001, 0, 1, 5'h00, 3'h0, 0};
        rows[3] = '{mac_d, mac_a, 5'h01, 1'b1, 3'h1, 12'h001, 0, 0, 5'h03, 3'h6, 0};
        rows[4] = '{48'h020000000013, mac_a, 5'h01, 1'b1, 3'h1, 12'h064, 0, 0, 5'h03, 3'h2, 0};
        rows[5] = '{48'h020000000014, mac_a, 5'h01, 1'b1, 3'h5, 12'h001, 0, 0, 5'h03, 3'h5, 0};
        rows[6] = '{48'h020000000015, mac_a, 5'h07, 1'b0, 3'h0, 12'h001, 0, 0, 5'h03, 3'h4, 0};
        rows[7] = '{mac_b, mac_a, 5'h05, 1'b0, 3'h0, 12'h001, 0, 0, 5'h03, 3'h0, 1};
        rows[8] = '{mac_b, mac_a, 5'h06, 1'b0, 3'h0, 12'h001, 0, 0, 5'h03, 3'h0, 0};
        rows[9] = '{48'h020000000016, mac_a, 5'h01, 1'b1, 3'h7, 12'h001, 0, 0, 5'h03, 3'h7, 0};
        repeat (6) @(posedge i_clock);
        i_rst <= 1'b0;
        creg(atab_pkg::REG_CTRL, 32'h0);
        creg(atab_pkg::REG_LEARN, atab_pkg::LEARN_RESET);
        creg(atab_pkg::REG_AGE, {12'h000, atab_pkg::AGE_DEFAULT_S});
        creg(atab_pkg::REG_PRIO_MAP, {8'h00, atab_pkg::PRIO_MAP_RESET});
        creg(atab_pkg::REG_QUEUE_MAP, {16'h0000, atab_pkg::QUEUE_MAP_RESET});
        creg(8'h3c, 32'h0);
        wreg(atab_pkg::REG_AGE, 32'h5);
        creg(atab_pkg::REG_AGE, 32'h1e);
        wreg(atab_pkg::REG_AGE, 32'h1e8480);
        creg(atab_pkg::REG_AGE, 32'hf4240);
        wreg(atab_pkg::REG_AGE, 32'h1e);
        $display("test registers done");
        ent(atab_pkg::OP_ADD, atab_pkg::K_STATIC, mac_a, 5'h03, 3'h0);
        ent(atab_pkg::OP_ADD, atab_pkg::K_BOUND, mac_b, 5'h05, 3'h0);
        ent(atab_pkg::OP_ADD, atab_pkg::K_FILTER, mac_c, 5'h00, 3'h0);
        ent(atab_pkg::OP_ADD, atab_pkg::K_CLASS, mac_d, 5'h00, 3'h6);
        ent(atab_pkg::OP_ADD, atab_pkg::K_VLAN, 48'h64, 5'h00, 3'h2);
        wreg(atab_pkg::REG_PORT_CLASS, 32'h00040700);
        foreach (rows[i]) begin
            look(rows[i]);
            `chk("drop", rows[i].drop, drop)
            `chk("flood", rows[i].flood, flood)
            if (!rows[i].drop) `chk("port", rows[i].oport, oport)
            `chk("class", rows[i].cls, cls)
            `chk("queue", atab_pkg::QUEUE_MAP_RESET[{rows[i].cls, 1'b0} +: 2], que)
            `chk("mgmt", rows[i].mok, mok)
        end
        $display("test classify rows done");
        ent(atab_pkg::OP_DEL, atab_pkg::K_CLASS, mac_d, 5'h00, 3'h0);
        look(rows[7]);
        look('{mac_d, mac_a, 5'h01, 1'b0, 3'h0, 12'h001, 0, 0, 5'h03, 3'h0, 0});
        `chk("class", 3'h0, cls)
        wreg(atab_pkg::REG_LEARN, 32'hfffffffb);
        look('{48'h020000000020, mac_a, 5'h02, 1'b0, 3'h0, 12'h001, 0, 0, 5'h03, 3'h0, 0});
        look('{mac_l, mac_a, 5'h01, 1'b0, 3'h0, 12'h001, 0, 0, 5'h03, 3'h0, 0});
        probe(48'h020000000020, 1'b1, 5'h00);
        probe(mac_l, 1'b0, 5'h01);
        // two scan periods of 30 s at 8 cycles a second, plus margin
        repeat (520) @(posedge i_clock);
        probe(mac_l, 1'b1, 5'h00);
        probe(mac_a, 1'b0, 5'h03);
        probe(mac_b, 1'b0, 5'h05);
        $display("test learning and aging done");
        wreg(atab_pkg::REG_CTRL, 32'h1);
        mask <= 4'h9;
        repeat (3) @(posedge i_clock);
        #1;
        `chk("grant", 3'h7, {gv, grant})
        mask <= 4'h3;
        repeat (3) @(posedge i_clock);
        #1;
        `chk("grant", 3'h5, {gv, grant})
        mask <= 4'h0;
        repeat (3) @(posedge i_clock);
        #1;
        `chk("grant valid", 1'b0, gv)
        wreg(atab_pkg::REG_CTRL, 32'h0);
        mask <= 4'hf;
        slow <= 1'b1;
        run  <= 1'b1;
        for (int i = 0; i < 100 && total != 5'h0f; i++) @(posedge i_clock);
        #1;
        `chk("served", {5'h08, 5'h04, 5'h02, 5'h01}, served)
        $display("test queue service done");
        // mid-run reset empties the table and restores the defaults
        i_rst <= 1'b1;
        repeat (2) @(posedge i_clock);
        `chk("reset outputs", 4'h0, {rv, gv, flood, mok})
        i_rst <= 1'b0;
        creg(atab_pkg::REG_STATUS, 32'h0);
        creg(atab_pkg::REG_WEIGHTS, {16'h0000, atab_pkg::WEIGHTS_RESET});
        $display("test reset done");
        conclude();
    end
endmodule
